// [smc_defines.svh]
// offsets, field positions, reset values and timing counts of the serial master
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SMC_OFF_CONTROL      8'h00
`define SMC_OFF_EDGE_A       8'h04
`define SMC_OFF_EDGE_B       8'h08
`define SMC_OFF_LAUNCH       8'h0C
`define SMC_OFF_IRQ_MASKED   8'h20
`define SMC_OFF_IRQ_RAW      8'h24
`define SMC_OFF_IRQ_CLEAR    8'h28
`define SMC_OFF_IRQ_EN_SET   8'h2C
`define SMC_OFF_IRQ_EN_CLR   8'h30
`define SMC_OFF_TX_ADDR      8'h40
`define SMC_OFF_TX_DATA      8'h50
`define SMC_OFF_RX_DATA      8'h60

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SMC_RXW_EN_BIT       29
`define SMC_RXW_MSB          28
`define SMC_RXW_LSB          24
`define SMC_ADW_EN_BIT       21
`define SMC_ADW_MSB          20
`define SMC_ADW_LSB          16
`define SMC_TDW_EN_BIT       13
`define SMC_TDW_MSB          12
`define SMC_TDW_LSB          8
`define SMC_SELB_WE_BIT      5
`define SMC_SELA_WE_BIT      4
`define SMC_SELB_LVL_BIT     3
`define SMC_SELA_LVL_BIT     2
`define SMC_RX_ON_BIT        1
`define SMC_TX_ON_BIT        0
`define SMC_CTRL_PLAIN_MASK  32'h3F3F3F03
`define SMC_CTRL_SEL_MASK    32'h0000000C
`define SMC_CTRL_READ_MASK   32'h3F3F3F0F
`define SMC_EDGE_MASK        32'h00000003
`define SMC_SAMPLE_EDGE_BIT  1
`define SMC_LAUNCH_EDGE_BIT  0

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define SMC_RST_CONTROL      32'h00000000
`define SMC_RST_EDGE         32'h00000001
`define SMC_RST_WORD         32'h00000000
`define SMC_MODE_TX          5'h0D
`define SMC_MODE_RX          5'h1B
`define SMC_MODE_TXRX        5'h17
`define SMC_RESP_OKAY        2'h0
`define SMC_RESP_SLVERR      2'h2
`define SMC_RESP_DECERR      2'h3

// ----------------------------------------------------------------
// serial clock timing
// ----------------------------------------------------------------
`define SMC_CLK_PERIOD_NS    10
`define SMC_SCK_HALF_NS      60
`define SMC_SCK_HALF_CYC     ((`SMC_SCK_HALF_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)

`endif

// [smc_pkg.sv]
// types shared by the serial master configuration block
`default_nettype none
package smc_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} smc_state_t;
  typedef enum logic [1:0] {MD_TX, MD_RX, MD_TXRX} smc_mode_t;

  typedef struct packed {
    logic        sdo;
    logic        sck;
    logic        selA;
    logic        selB;
  } smc_pins_t;

  typedef struct packed {
    smc_state_t  st;
    smc_mode_t   mode;
    logic [31:0] ctrl;
    logic [1:0]  edgeA;
    logic [1:0]  edgeB;
    logic        useB;
    logic        launch;
    logic        raw;
    logic        irqEn;
    logic [31:0] txAddr;
    logic [31:0] txData;
    logic [31:0] rxWord;
    logic [31:0] shiftOut;
    logic [31:0] rxShift;
    logic [5:0]  bitCnt;
    logic [5:0]  phaseLen;
    logic [3:0]  halfCnt;
    logic        sck;
    logic        sdo;
    logic        syncA;
    logic        syncB;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } smc_regs_t;

endpackage : smc_pkg
`default_nettype wire

// [smc_serial_master.sv]
// serial master: register file, mode decode, select control and shift engine
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`include "smc_defines.svh"
`default_nettype none
module smc_serial_master (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // axi4-lite write channels
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // serial link
  input  wire logic              serial_data_in,
  output var smc_pkg::smc_pins_t linkPins
);
  import smc_pkg::*;

  smc_regs_t   r;
  smc_regs_t   next_r;
  logic [4:0]  modeBits;
  logic        modeOk;
  smc_mode_t   modeDec;
  logic        wrFire;
  logic        wrFull;
  logic        ctrlWrite;
  logic        startNow;
  logic [1:0]  edgeSel;
  logic        launchFall;
  logic        sampleFall;
  logic        txPhase;
  logic        rxPhase;
  logic [5:0]  rxLen;
  logic [5:0]  adLen;
  logic [5:0]  tdLen;
  logic        busy;

  // ----------------------------------------------------------------
  // mode decode and phase lengths
  // ----------------------------------------------------------------
  assign modeBits = {r.ctrl[`SMC_RXW_EN_BIT], r.ctrl[`SMC_ADW_EN_BIT], r.ctrl[`SMC_TDW_EN_BIT],
                     r.ctrl[`SMC_RX_ON_BIT], r.ctrl[`SMC_TX_ON_BIT]};
  assign modeOk = (modeBits == `SMC_MODE_TX) || (modeBits == `SMC_MODE_RX)
                  || (modeBits == `SMC_MODE_TXRX);
  assign modeDec = (modeBits == `SMC_MODE_TX) ? MD_TX :
                   (modeBits == `SMC_MODE_RX) ? MD_RX : MD_TXRX;
  // a disabled width gives a zero-length phase; the field itself is kept
  assign rxLen = r.ctrl[`SMC_RXW_EN_BIT] ?
                 {1'b0, r.ctrl[`SMC_RXW_MSB:`SMC_RXW_LSB]} + 6'h01 : 6'h00;
  assign adLen = r.ctrl[`SMC_ADW_EN_BIT] ?
                 {1'b0, r.ctrl[`SMC_ADW_MSB:`SMC_ADW_LSB]} + 6'h01 : 6'h00;
  assign tdLen = r.ctrl[`SMC_TDW_EN_BIT] ?
                 {1'b0, r.ctrl[`SMC_TDW_MSB:`SMC_TDW_LSB]} + 6'h01 : 6'h00;

  // edges come from the register of whichever select was last chosen
  assign edgeSel    = r.useB ? r.edgeB : r.edgeA;
  assign launchFall = edgeSel[`SMC_LAUNCH_EDGE_BIT];
  assign sampleFall = edgeSel[`SMC_SAMPLE_EDGE_BIT];
  assign txPhase    = (r.st == ST_ADDR) || (r.mode != MD_RX);
  assign rxPhase    = (r.st == ST_DATA) && (r.mode != MD_TX);
  assign busy       = (r.st != ST_IDLE);

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign wrFire        = r.awHeld && r.wHeld;
  assign wrFull        = (r.wStrb == 4'hF);
  assign ctrlWrite     = wrFire && wrFull && (r.awAddr == `SMC_OFF_CONTROL);
  assign startNow      = wrFire && wrFull && (r.awAddr == `SMC_OFF_LAUNCH) && r.wData[0]
                         && modeOk && !r.raw && !busy;
  assign s_axi_awready = !r.awHeld && !r.bvalid;
  assign s_axi_wready  = !r.wHeld && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign linkPins.sdo  = r.sdo;
  assign linkPins.sck  = r.sck;
  assign linkPins.selA = r.ctrl[`SMC_SELA_LVL_BIT];
  assign linkPins.selB = r.ctrl[`SMC_SELB_LVL_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.syncA = serial_data_in;
    next_r.syncB = r.syncA;

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.wHeld = 1'b1;
      next_r.wData = s_axi_wdata;
      next_r.wStrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;

    if (wrFire)
    begin
      next_r.awHeld = 1'b0;
      next_r.wHeld  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = `SMC_RESP_OKAY;
      if (!wrFull)
        next_r.bresp = `SMC_RESP_SLVERR;
      else if (r.awAddr == `SMC_OFF_CONTROL)
      begin
        // enables are write-only; levels move only with their enable
        next_r.ctrl = (r.wData & `SMC_CTRL_PLAIN_MASK) | (r.ctrl & `SMC_CTRL_SEL_MASK);
        if (r.wData[`SMC_SELA_WE_BIT])
          next_r.ctrl[`SMC_SELA_LVL_BIT] = r.wData[`SMC_SELA_LVL_BIT];
        if (r.wData[`SMC_SELB_WE_BIT])
          next_r.ctrl[`SMC_SELB_LVL_BIT] = r.wData[`SMC_SELB_LVL_BIT];
        if (r.wData[`SMC_SELB_WE_BIT] && !r.wData[`SMC_SELA_WE_BIT])
          next_r.useB = 1'b1;
        else if (r.wData[`SMC_SELA_WE_BIT] && !r.wData[`SMC_SELB_WE_BIT])
          next_r.useB = 1'b0;
      end
      else if (r.awAddr == `SMC_OFF_EDGE_A)
        next_r.edgeA = r.wData[1:0];
      else if (r.awAddr == `SMC_OFF_EDGE_B)
        next_r.edgeB = r.wData[1:0];
      else if (r.awAddr == `SMC_OFF_LAUNCH)
      begin
        // an unstartable launch stays set until software writes zero
        next_r.launch = r.wData[0];
        if (!r.wData[0])
        begin
          next_r.st  = ST_IDLE;
          next_r.sck = 1'b0;
          next_r.sdo = 1'b0;
        end
      end
      else if (r.awAddr == `SMC_OFF_IRQ_CLEAR)
      begin
        if (r.wData[0])
          next_r.raw = 1'b0;
      end
      else if (r.awAddr == `SMC_OFF_IRQ_EN_SET)
      begin
        if (r.wData[0])
          next_r.irqEn = 1'b1;
      end
      else if (r.awAddr == `SMC_OFF_IRQ_EN_CLR)
      begin
        if (r.wData[0])
          next_r.irqEn = 1'b0;
      end
      else if (r.awAddr == `SMC_OFF_TX_ADDR)
        next_r.txAddr = r.wData;
      else if (r.awAddr == `SMC_OFF_TX_DATA)
        next_r.txData = r.wData;
      else if (r.awAddr == `SMC_OFF_IRQ_MASKED || r.awAddr == `SMC_OFF_IRQ_RAW
               || r.awAddr == `SMC_OFF_RX_DATA)
        next_r.bresp = `SMC_RESP_OKAY;
      else
        next_r.bresp = `SMC_RESP_DECERR;
    end

    // read channel
    if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = `SMC_RESP_OKAY;
      if (s_axi_araddr == `SMC_OFF_CONTROL)
        next_r.rdata = r.ctrl & `SMC_CTRL_READ_MASK;
      else if (s_axi_araddr == `SMC_OFF_EDGE_A)
        next_r.rdata = {30'h0, r.edgeA};
      else if (s_axi_araddr == `SMC_OFF_EDGE_B)
        next_r.rdata = {30'h0, r.edgeB};
      else if (s_axi_araddr == `SMC_OFF_LAUNCH)
        next_r.rdata = {31'h0, r.launch};
      else if (s_axi_araddr == `SMC_OFF_IRQ_MASKED)
        next_r.rdata = {31'h0, r.raw & r.irqEn};
      else if (s_axi_araddr == `SMC_OFF_IRQ_RAW)
        next_r.rdata = {31'h0, r.raw};
      else if (s_axi_araddr == `SMC_OFF_IRQ_EN_SET)
        next_r.rdata = {31'h0, r.irqEn};
      else if (s_axi_araddr == `SMC_OFF_TX_ADDR)
        next_r.rdata = r.txAddr;
      else if (s_axi_araddr == `SMC_OFF_TX_DATA)
        next_r.rdata = r.txData;
      else if (s_axi_araddr == `SMC_OFF_RX_DATA)
        next_r.rdata = r.rxWord;
      else if (s_axi_araddr == `SMC_OFF_IRQ_CLEAR || s_axi_araddr == `SMC_OFF_IRQ_EN_CLR)
        next_r.rdata = `SMC_RST_WORD;
      else
      begin
        next_r.rdata = `SMC_RST_WORD;
        next_r.rresp = `SMC_RESP_DECERR;
      end
    end

    // ----------------------------------------------------------------
    // shift engine
    // ----------------------------------------------------------------
    if (startNow)
    begin
      next_r.mode     = modeDec;
      next_r.bitCnt   = 6'h00;
      next_r.halfCnt  = 4'h0;
      next_r.sck      = 1'b0;
      next_r.rxShift  = `SMC_RST_WORD;
      if (modeDec == MD_TXRX)
      begin
        next_r.st       = ST_DATA;
        next_r.phaseLen = (rxLen > tdLen) ? rxLen : tdLen;
        next_r.shiftOut = r.txData;
      end
      else
      begin
        next_r.st       = ST_ADDR;
        next_r.phaseLen = adLen;
        next_r.shiftOut = r.txAddr;
      end
      next_r.sdo = launchFall ? next_r.shiftOut[31] : 1'b0;
      if (launchFall)
        next_r.shiftOut = {next_r.shiftOut[30:0], 1'b0};
    end
    else if (busy && next_r.st != ST_IDLE)
    begin
      next_r.halfCnt = r.halfCnt + 4'h1;
      if (r.halfCnt == 4'(`SMC_SCK_HALF_CYC - 1))
      begin
        next_r.halfCnt = 4'h0;
        next_r.sck     = !r.sck;
        if (!r.sck)
        begin
          if (!launchFall && txPhase)
          begin
            next_r.sdo      = r.shiftOut[31];
            next_r.shiftOut = {r.shiftOut[30:0], 1'b0};
          end
          if (!sampleFall && rxPhase && r.bitCnt < rxLen)
            next_r.rxShift = {r.rxShift[30:0], r.syncB};
        end
        else
        begin
          if (sampleFall && rxPhase && r.bitCnt < rxLen)
            next_r.rxShift = {r.rxShift[30:0], r.syncB};
          next_r.bitCnt = r.bitCnt + 6'h01;
          if (r.bitCnt + 6'h01 == r.phaseLen)
          begin
            next_r.bitCnt = 6'h00;
            if (r.st == ST_ADDR)
            begin
              next_r.st       = ST_DATA;
              next_r.phaseLen = (r.mode == MD_RX) ? rxLen : tdLen;
              next_r.shiftOut = (r.mode == MD_RX) ? `SMC_RST_WORD : r.txData;
              next_r.sdo      = launchFall ? next_r.shiftOut[31] : 1'b0;
              if (launchFall)
                next_r.shiftOut = {next_r.shiftOut[30:0], 1'b0};
            end
            else
            begin
              // completion flag set after the clear above, so it wins
              next_r.st     = ST_IDLE;
              next_r.launch = 1'b0;
              next_r.raw    = 1'b1;
              next_r.sdo    = 1'b0;
              next_r.rxWord = (r.mode == MD_TX) ? r.rxWord : next_r.rxShift;
            end
          end
          else if (launchFall && txPhase)
          begin
            next_r.sdo      = r.shiftOut[31];
            next_r.shiftOut = {r.shiftOut[30:0], 1'b0};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.mode   <= MD_TX;
      r.ctrl   <= `SMC_RST_CONTROL;
      r.edgeA  <= 2'(`SMC_RST_EDGE);
      r.edgeB  <= 2'(`SMC_RST_EDGE);
    end
    else if (ce)
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  legal_start_a: assert property ($rose(busy) |-> $past(modeOk))
    else $error("transfer started with an illegal mode");
  launch_busy_a: assert property (busy |-> r.launch)
    else $error("launch bit low during a transfer");
  launch_clear_a: assert property ($fell(busy) && $past(r.launch) |-> !r.launch && r.raw)
    else $error("completion did not clear launch or set flag");
  sck_idle_a: assert property (!busy |-> !linkPins.sck)
    else $error("serial clock moved while idle");
  sck_half_a: assert property ($rose(linkPins.sck) |-> linkPins.sck[*6])
    else $error("serial clock high time wrong");
  sel_hold_a: assert property (!(ctrlWrite && r.wData[`SMC_SELA_WE_BIT])
                               |=> $stable(linkPins.selA))
    else $error("select a moved without its enable");
  sel_follow_a: assert property (ctrlWrite && r.wData[`SMC_SELB_WE_BIT]
                                 |=> linkPins.selB == $past(r.wData[`SMC_SELB_LVL_BIT]))
    else $error("select b did not take written level");
  rx_align_a: assert property ($fell(busy) && r.mode != MD_TX
                               |-> (r.rxWord >> rxLen) == 32'h0)
    else $error("receive word has bits above width");
  ctrl_reserved_a: assert property ((r.ctrl & ~`SMC_CTRL_READ_MASK) == 32'h0)
    else $error("reserved control bits set");
  partial_refused_a: assert property (wrFire && !wrFull
                                      |=> $stable(r.ctrl) && s_axi_bresp == `SMC_RESP_SLVERR)
    else $error("partial write not refused");
  addr_first_a: assert property ($rose(busy) && r.mode != MD_TXRX |-> r.st == ST_ADDR)
    else $error("transfer skipped the address phase");

  tx_done_c: cover property ($fell(busy) && r.mode == MD_TX);
  rx_done_c: cover property ($fell(busy) && r.mode == MD_RX);
  txrx_done_c: cover property ($fell(busy) && r.mode == MD_TXRX);
  bad_launch_c: cover property (r.launch && !busy && !modeOk);

endmodule : smc_serial_master
`default_nettype wire

// [smc_slave_model.sv]
// serial slave model answering on the receive data line
`default_nettype none
module smc_slave_model (
  // link side
  input  wire logic               clk,
  input  wire smc_pkg::smc_pins_t pins,
  // bit pattern to return, msb first
  input  wire logic [31:0]        pattern,
  output logic                    sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;
  logic       prevSck;
  logic [5:0] idx;
  initial
  begin
    sdi = 1'b0;
    prevSck = 1'b0;
    idx = '0;
  end
  always @(posedge clk)
  begin
    prevSck <= pins.sck;
    if (!pins.selA && !pins.selB)
    begin
      // not selected: toggle so no stale level looks valid
      sdi <= ~sdi;
      idx <= '0;
    end
    else
    begin
      sdi <= pattern[5'd31 - idx[4:0]];
      // change only after a falling edge, stable for the rising sample
      if (prevSck && !pins.sck)
        idx <= idx + 6'd1;
    end
  end
endmodule : smc_slave_model
`default_nettype wire

// [serial_master_config_and_select_tb.sv]
// self-checking bench for the serial master configuration block
`include "smc_defines.svh"
`default_nettype none
module serial_master_config_and_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;
  logic        clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready, sdi, prevSck, irqEn;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, pattern, seed, d, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, selLvl;
  smc_pins_t   pins;
  int          n_fail, compares;
  logic        sdoQ[$], sdiQ[$];
  logic [7:0]  offs [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h2C,
                             8'h30, 8'h40, 8'h50, 8'h60};
  smc_serial_master u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_data_in(sdi), .linkPins(pins));
  smc_slave_model u_slave (.clk(clk), .pins(pins), .pattern(pattern), .sdi(sdi));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // bench view of the wire: one entry per serial clock rise
  always @(posedge clk)
  begin
    prevSck <= pins.sck;
    if (pins.sck && !prevSck)
    begin
      sdoQ.push_back(pins.sdo);
      sdiQ.push_back(sdi);
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the wait ends when bvalid is seen; only the watchdog ends one that never gets it
    forever
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
  endtask : rdchk
  // one transfer in mode md with random widths and words
  task automatic xfer(input logic [4:0] md);
    logic [31:0] ta, td, ctl, rx;
    int aL, dL, rL, n, st, fz;
    seed = lfsr(seed);
    ta = seed;
    seed = lfsr(seed);
    td = seed;
    seed = lfsr(seed);
    pattern = seed;
    ctl = (ta ^ td) & 32'h1F1F1F00;
    {ctl[29], ctl[21], ctl[13], ctl[1], ctl[0]} = md;
    ctl[5:2] = 4'b0101;
    rL = md[4] ? ctl[28:24] + 1 : 0;
    aL = md[3] ? ctl[20:16] + 1 : 0;
    dL = md[2] ? ctl[12:8] + 1 : 0;
    n = (md == `SMC_MODE_TXRX) ? (dL > rL ? dL : rL) : aL + dL + rL;
    st = (md == `SMC_MODE_RX) ? aL : 0;
    wr(`SMC_OFF_TX_ADDR, ta, 4'hF);
    wr(`SMC_OFF_TX_DATA, td, 4'hF);
    wr(`SMC_OFF_CONTROL, ctl, 4'hF);
    chk("select a", 1, pins.selA);
    sdoQ.delete();
    sdiQ.delete();
    wr(`SMC_OFF_LAUNCH, 1, 4'hF);
    // enable low must freeze the running transfer
    ce <= 1'b0;
    fz = sdoQ.size();
    repeat (30) @(posedge clk);
    chk("frozen", fz, sdoQ.size());
    ce <= 1'b1;
    rdchk(`SMC_OFF_LAUNCH, 1);
    for (int k = 0; k < 600 && d[0]; k++)
      rd(`SMC_OFF_LAUNCH);
    chk("launch done", 0, d);
    chk("sck rises", n, sdoQ.size());
    for (int i = 0; i < n && i < sdoQ.size(); i++)
      if (md == `SMC_MODE_TXRX)
        chk("sdo", td[31 - i], sdoQ[i]);
      else if (i < aL)
        chk("sdo addr", ta[31 - i], sdoQ[i]);
      else if (md == `SMC_MODE_TX)
        chk("sdo data", td[31 - i + aL], sdoQ[i]);
    rx = 0;
    for (int j = 0; j < rL && st + j < sdiQ.size(); j++)
      rx = {rx[30:0], sdiQ[st + j]};
    rdchk(`SMC_OFF_RX_DATA, rx);
    rdchk(`SMC_OFF_IRQ_RAW, 1);
    rdchk(`SMC_OFF_IRQ_MASKED, {31'b0, irqEn});
    wr(`SMC_OFF_IRQ_CLEAR, 1, 4'hF);
    rdchk(`SMC_OFF_IRQ_RAW, 0);
    wr(`SMC_OFF_CONTROL, ctl & ~32'h4, 4'hF);
    chk("select a off", 0, pins.selA);
  endtask : xfer
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {n_fail, compares, selLvl, irqEn, prevSck} = '0;
    seed = 32'h776B;
    pattern = '0;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++)
      rdchk(offs[i], (i == 1 || i == 2) ? 1 : 0);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      v = seed;
      if (v[4])
        selLvl[0] = v[2];
      if (v[5])
        selLvl[1] = v[3];
      // never leave both selects asserted
      if (selLvl == 2'b11)
      begin
        v[5] = 1'b1;
        v[3] = 1'b0;
        selLvl[1] = 1'b0;
      end
      wr(`SMC_OFF_CONTROL, v, 4'hF);
      rdchk(`SMC_OFF_CONTROL, v & 32'h3F3F3F03 | {selLvl, 2'b0});
      chk("pins", selLvl, {pins.selB, pins.selA});
    end
    wr(`SMC_OFF_CONTROL, 32'hFFFFFFFF, 4'h7);
    chk("resp strb", 2, r);
    rdchk(`SMC_OFF_CONTROL, v & 32'h3F3F3F03 | {selLvl, 2'b0});
    wr(8'h14, 1, 4'hF);
    chk("resp hole", 3, r);
    rd(8'h14);
    chk("rresp hole", 3, r);
    wr(`SMC_OFF_EDGE_A, 32'hFFFFFFFF, 4'hF);
    rdchk(`SMC_OFF_EDGE_A, 3);
    wr(`SMC_OFF_EDGE_A, 1, 4'hF);
    wr(`SMC_OFF_CONTROL, 32'h00000033, 4'hF);
    sdoQ.delete();
    wr(`SMC_OFF_LAUNCH, 1, 4'hF);
    repeat (40) @(posedge clk);
    chk("no start", 0, sdoQ.size());
    rdchk(`SMC_OFF_LAUNCH, 1);
    wr(`SMC_OFF_LAUNCH, 0, 4'hF);
    wr(`SMC_OFF_IRQ_EN_SET, 1, 4'hF);
    irqEn = 1'b1;
    xfer(`SMC_MODE_TX);
    xfer(`SMC_MODE_RX);
    wr(`SMC_OFF_IRQ_EN_CLR, 1, 4'hF);
    irqEn = 1'b0;
    rdchk(`SMC_OFF_IRQ_EN_SET, 0);
    xfer(`SMC_MODE_TXRX);
    complete_run();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : serial_master_config_and_select_tb
`default_nettype wire
